// ---- frabo_pkg.sv ----
// Constants for the file-register ALU and bit-operation block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package frabo_pkg;
  // Instruction word layout
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int FADDR_LSB = 0;
  localparam int DEST_POS = 7;
  localparam int BITIDX_LSB = 7;
  localparam int BITIDX_W = 3;
  localparam int BYTE_OP_LSB = 8;
  localparam int BIT_OP_LSB = 10;
  // Byte-operation opcodes (bits 13:8)
  localparam logic [5:0] OPC_ADD_ACC_FILE = 6'h07;
  localparam logic [5:0] OPC_AND_ACC_FILE = 6'h05;
  // Bit-operation opcodes (bits 13:10)
  localparam logic [3:0] OPC_BIT_CLEAR_FILE = 4'h4;
  localparam logic [3:0] OPC_BIT_TEST_SKIP_ZERO = 4'h6;
  // Destination select values
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // Register port map (8-bit address)
  localparam int BUS_ADDR_W = 8;
  localparam logic [7:0] ADDR_FILE_LAST = 8'h7F;
  localparam logic [7:0] ADDR_ACC = 8'h80;
  localparam logic [7:0] ADDR_STATUS = 8'h81;
  localparam logic [7:0] ADDR_CTRL = 8'h82;
  // Status register fields
  localparam int STAT_CARRY_POS = 0;
  localparam int STAT_NIBBLE_POS = 1;
  localparam int STAT_ZERO_POS = 2;
  // Control register fields and reset values
  localparam int CTRL_RUN_POS = 0;
  localparam logic CTRL_RUN_RESET = 1'b0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // File address that maps onto the I/O port pins
  localparam logic [6:0] PORT_ADDR_DEFAULT = 7'h06;
  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;
endpackage : frabo_pkg

// ---- frabo_core.sv ----
// Executes add/AND of accumulator with a file byte, bit clear and
// bit test with skip on zero, over a 128-byte register file.
// Assumes program memory presents one prefetched word per clock on
// instr_i and that the wider core handles all other opcodes.
//
// Notes on behaviour
// - Add acc and file byte; set carry, nibble, zero; one cycle
// - AND accumulator with file byte, update only zero, one cycle
// - Destination bit 0 writes accumulator, 1 writes file register
// - File address is 7 bits (0..127), destination is one bit
// - Bit clear zeroes selected file bit, flags unchanged, one cycle
// - Bit test skips next word when bit is zero, flags unchanged
// - A skip discards the prefetched word and runs an idle cycle
// - Read-modify-write of port register reads pins, writes back
`timescale 1ns/10ps

// Timing of the instruction stream
// Each rising edge executes the word on instr_i when the run bit is set
// and no skip is pending. Results land at that same edge, so the new
// accumulator, flags and file byte are visible in the following cycle.
// A taken bit test raises skip_o for exactly one cycle; the word that
// program memory presents in that cycle is ignored, whatever it holds,
// including a second bit test. That idle cycle is the second cycle of
// the two-cycle form of the test.
//
// Register port
// Addresses 0x00 to 0x7F reach the file bytes, 0x80 the accumulator,
// 0x81 the status flags and 0x82 the control word with the run bit.
// Writes take effect at the strobe edge; reads answer one cycle later
// and the answer stands for that single cycle only, then drops to zero.
// Unmapped addresses ignore writes and read back as zero. The slave
// never stalls, so a master may issue strobes back to back.
//
// Clash between software and an executing word
// Software writes are applied first in the next-state logic and the
// executing word is applied after them, so the word wins whenever both
// touch the same accumulator, flag or file byte in one cycle. Software
// that must not lose a write should halt the core through the run bit.
//
// Port location
// One file address is mapped onto the I/O pins. Operand reads there see
// the filtered pin levels rather than the output latch, so any
// read-modify-write copies the external drive back into the latch. A
// pin held low by another device therefore clears its latch bit even if
// the instruction meant to touch a different bit. This is the intended
// behaviour of the port, and users must keep it in mind.
//
// Pin filter
// Pins pass three flip-flops. The first stage may go metastable and is
// read only by the second. A new level is accepted once the second and
// third stages agree, which also rejects a single-cycle glitch. The
// cost is a latency of three to four cycles before a pin change shows.
//
// Flags
// The add updates carry, nibble carry and zero; the AND updates zero
// only; bit clear and bit test leave all flags as they were. The zero
// flag always reflects the full 8-bit result, regardless of where the
// destination bit sends that result.
//
// Reset
// The asynchronous reset clears the accumulator, the flags, the skip
// state, the read answer, the port latch and the pin filter, and halts
// the core. The file array has no reset so that it can map onto plain
// memory; its contents are unknown until software writes them.
//
// Decoding
// Opcodes outside the four supported forms have no effect here; the
// wider core decodes them. An all-zero word is therefore a safe filler
// for cycles in which program memory has nothing to present.
//
module frabo_core #(
  parameter logic [6:0] PORT_ADDR = frabo_pkg::PORT_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Instruction word from program memory
  input wire logic [frabo_pkg::INSTR_W-1:0] instr_i,
  // Register port
  input wire logic [frabo_pkg::BUS_ADDR_W-1:0] addr_i,
  input wire logic [frabo_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [frabo_pkg::DATA_W-1:0] rdata_o,
  // I/O port pins
  input wire logic [frabo_pkg::DATA_W-1:0] port_pins_i,
  output logic [frabo_pkg::DATA_W-1:0] port_latch_o,
  // Core state
  output logic [frabo_pkg::DATA_W-1:0] acc_o,
  output logic carry_o,
  output logic nibble_overflow_flag_o,
  output logic zero_o,
  output logic skip_o
);

  localparam int DW = frabo_pkg::DATA_W;

  // Register file storage
  logic [DW-1:0] file_mem [0:127];

  // Architectural state
  logic [DW-1:0] acc_reg, acc_next;
  logic carry_reg, carry_next;
  logic nibble_reg, nibble_next;
  logic zero_reg, zero_next;
  logic flush_reg, flush_next;
  logic run_reg, run_next;
  logic [DW-1:0] port_latch_reg, port_latch_next;
  logic [DW-1:0] rdata_reg, rdata_next;

  // Pin synchroniser state
  logic [DW-1:0] sync1_reg, sync2_reg, sync3_reg;
  logic [DW-1:0] pins_reg, pins_next;

  // Decode signals
  logic [frabo_pkg::FADDR_W-1:0] faddr;
  logic dest;
  logic [frabo_pkg::BITIDX_W-1:0] bidx;
  logic [5:0] byte_op;
  logic [3:0] bit_op;
  logic exec;
  logic [DW-1:0] file_rd;
  logic [DW:0] sum9;
  logic [4:0] sum5;
  logic [DW-1:0] result;

  // File write port
  logic fwr_en;
  logic [frabo_pkg::FADDR_W-1:0] fwr_addr;
  logic [DW-1:0] fwr_data;

  // Field extraction; only 7 address bits exist, so 0..127
  assign faddr =
    instr_i[frabo_pkg::FADDR_LSB +: frabo_pkg::FADDR_W];
  assign dest = instr_i[frabo_pkg::DEST_POS];
  assign bidx = instr_i[frabo_pkg::BITIDX_LSB +: frabo_pkg::BITIDX_W];
  assign byte_op = instr_i[frabo_pkg::BYTE_OP_LSB +: 6];
  assign bit_op = instr_i[frabo_pkg::BIT_OP_LSB +: 4];
  // A discarded prefetch or a halted core executes nothing
  assign exec = run_reg && !flush_reg;

  // Operand read; the port location reads the pin levels, not the
  // latch, so a read-modify-write copies external drive back in
  always_comb begin
    if (faddr == PORT_ADDR) begin
      file_rd = pins_reg;
    end else begin
      file_rd = file_mem[faddr];
    end
  end

  // Adder with a separate low-nibble sum for the nibble carry
  assign sum9 = {1'b0, acc_reg} + {1'b0, file_rd};
  assign sum5 = {1'b0, acc_reg[3:0]} + {1'b0, file_rd[3:0]};

  // Instruction execution and register port writes
  always_comb begin
    acc_next = acc_reg;
    carry_next = carry_reg;
    nibble_next = nibble_reg;
    zero_next = zero_reg;
    flush_next = 1'b0;
    run_next = run_reg;
    fwr_en = 1'b0;
    fwr_addr = faddr;
    fwr_data = file_rd;
    result = frabo_pkg::DATA_RESET;
    // Software writes first, so an executing instruction wins a clash
    if (wr_i) begin
      if (addr_i <= frabo_pkg::ADDR_FILE_LAST) begin
        fwr_en = 1'b1;
        fwr_addr = addr_i[frabo_pkg::FADDR_W-1:0];
        fwr_data = wdata_i;
      end else if (addr_i == frabo_pkg::ADDR_ACC) begin
        acc_next = wdata_i;
      end else if (addr_i == frabo_pkg::ADDR_STATUS) begin
        carry_next = wdata_i[frabo_pkg::STAT_CARRY_POS];
        nibble_next = wdata_i[frabo_pkg::STAT_NIBBLE_POS];
        zero_next = wdata_i[frabo_pkg::STAT_ZERO_POS];
      end else if (addr_i == frabo_pkg::ADDR_CTRL) begin
        run_next = wdata_i[frabo_pkg::CTRL_RUN_POS];
      end
    end
    if (exec) begin
      if (byte_op == frabo_pkg::OPC_ADD_ACC_FILE) begin
        result = sum9[DW-1:0];
        carry_next = sum9[DW];
        nibble_next = sum5[4];
        zero_next = (result == frabo_pkg::DATA_RESET);
      end else if (byte_op == frabo_pkg::OPC_AND_ACC_FILE) begin
        result = acc_reg & file_rd;
        zero_next = (result == frabo_pkg::DATA_RESET);
      end
      if (byte_op == frabo_pkg::OPC_ADD_ACC_FILE ||
          byte_op == frabo_pkg::OPC_AND_ACC_FILE) begin
        if (dest == frabo_pkg::DEST_ACC) begin
          acc_next = result;
        end else begin
          fwr_en = 1'b1;
          fwr_addr = faddr;
          fwr_data = result;
        end
      end else if (bit_op == frabo_pkg::OPC_BIT_CLEAR_FILE) begin
        // Whole byte is rewritten; flags are left alone
        fwr_en = 1'b1;
        fwr_addr = faddr;
        fwr_data = file_rd;
        fwr_data[bidx] = 1'b0;
      end else if (bit_op == frabo_pkg::OPC_BIT_TEST_SKIP_ZERO) begin
        flush_next = !file_rd[bidx];
      end
    end
  end

  // Port latch follows any write that lands on the port location
  always_comb begin
    port_latch_next = port_latch_reg;
    if (fwr_en && fwr_addr == PORT_ADDR) begin
      port_latch_next = fwr_data;
    end
  end

  // Register port read, answered in the following cycle only
  always_comb begin
    rdata_next = frabo_pkg::DATA_RESET;
    if (rd_i) begin
      if (addr_i <= frabo_pkg::ADDR_FILE_LAST) begin
        if (addr_i[frabo_pkg::FADDR_W-1:0] == PORT_ADDR) begin
          rdata_next = pins_reg;
        end else begin
          rdata_next = file_mem[addr_i[frabo_pkg::FADDR_W-1:0]];
        end
      end else if (addr_i == frabo_pkg::ADDR_ACC) begin
        rdata_next = acc_reg;
      end else if (addr_i == frabo_pkg::ADDR_STATUS) begin
        rdata_next[frabo_pkg::STAT_CARRY_POS] = carry_reg;
        rdata_next[frabo_pkg::STAT_NIBBLE_POS] = nibble_reg;
        rdata_next[frabo_pkg::STAT_ZERO_POS] = zero_reg;
      end else if (addr_i == frabo_pkg::ADDR_CTRL) begin
        rdata_next[frabo_pkg::CTRL_RUN_POS] = run_reg;
      end
    end
  end

  // Pin filter: accept a new level once stages two and three agree
  always_comb begin
    pins_next = pins_reg;
    if (sync2_reg == sync3_reg) begin
      pins_next = sync3_reg;
    end
  end

  // State registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_reg <= frabo_pkg::DATA_RESET;
      carry_reg <= 1'b0;
      nibble_reg <= 1'b0;
      zero_reg <= 1'b0;
      flush_reg <= 1'b0;
      run_reg <= frabo_pkg::CTRL_RUN_RESET;
      port_latch_reg <= frabo_pkg::DATA_RESET;
      rdata_reg <= frabo_pkg::DATA_RESET;
      sync1_reg <= frabo_pkg::DATA_RESET;
      sync2_reg <= frabo_pkg::DATA_RESET;
      sync3_reg <= frabo_pkg::DATA_RESET;
      pins_reg <= frabo_pkg::DATA_RESET;
    end else begin
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      nibble_reg <= nibble_next;
      zero_reg <= zero_next;
      flush_reg <= flush_next;
      run_reg <= run_next;
      port_latch_reg <= port_latch_next;
      rdata_reg <= rdata_next;
      sync1_reg <= port_pins_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pins_reg <= pins_next;
    end
  end

  // File array has no reset; software initialises what it uses
  always_ff @(posedge clk_i) begin
    if (fwr_en) begin
      file_mem[fwr_addr] <= fwr_data;
    end
  end

  // Outputs straight from flip-flops
  assign rdata_o = rdata_reg;
  assign port_latch_o = port_latch_reg;
  assign acc_o = acc_reg;
  assign carry_o = carry_reg;
  assign nibble_overflow_flag_o = nibble_reg;
  assign zero_o = zero_reg;
  assign skip_o = flush_reg;

endmodule : frabo_core

// ---- frabo_core_sva.sv ----
// Checker for the file-register ALU block, on top-level ports only.
// Assumes the run bit changes only through bus writes to control.
`timescale 1ns/10ps
module frabo_core_sva #(
  parameter logic [6:0] PORT_ADDR = frabo_pkg::PORT_ADDR_DEFAULT
) (
  // Clock, reset and stimulus
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  // Core state
  input wire logic [7:0] port_latch_o,
  input wire logic [7:0] acc_o,
  input wire logic carry_o,
  input wire logic nibble_overflow_flag_o,
  input wire logic zero_o,
  input wire logic skip_o
);
  logic run_reg;
  logic run_next;
  logic ex;
  logic add_w;
  logic and_w;
  logic bcf_w;
  logic btz_w;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Mirror of the run bit, so we know when a word really executes
  always_comb begin
    run_next = run_reg;
    if (wr_i && addr_i == frabo_pkg::ADDR_CTRL) run_next = wdata_i[0];
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) run_reg <= 1'b0;
    else run_reg <= run_next;
  end
  // Bus writes excluded: they would blur flag and acc checks
  assign ex = run_reg && !skip_o && !wr_i;
  assign add_w = ex && instr_i[13:8] == frabo_pkg::OPC_ADD_ACC_FILE;
  assign and_w = ex && instr_i[13:8] == frabo_pkg::OPC_AND_ACC_FILE;
  assign bcf_w = ex && instr_i[13:10] == frabo_pkg::OPC_BIT_CLEAR_FILE;
  assign btz_w = ex && instr_i[13:10] == frabo_pkg::OPC_BIT_TEST_SKIP_ZERO;
  property p_add_flags;
    add_w && !instr_i[7] |=> carry_o == (acc_o < $past(acc_o)) &&
      nibble_overflow_flag_o == (acc_o[3:0] < $past(acc_o[3:0]));
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags");
  property p_zero;
    (add_w || and_w) && !instr_i[7] |=> zero_o == (acc_o == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag");
  property p_and_mask;
    and_w && !instr_i[7] |=> (acc_o & ~$past(acc_o)) == 8'h00 &&
      $stable(carry_o) && $stable(nibble_overflow_flag_o);
  endproperty
  a_and_mask: assert property (p_and_mask) else $error("and result");
  property p_dest_file;
    (add_w || and_w) && instr_i[7] |=> $stable(acc_o);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("dest");
  property p_bit_flags;
    bcf_w || btz_w |=> $stable({carry_o, nibble_overflow_flag_o, zero_o});
  endproperty
  a_bit_flags: assert property (p_bit_flags)
    else $error("flags");
  property p_skip_cause;
    $rose(skip_o) |-> $past(run_reg && !skip_o &&
      instr_i[13:10] == frabo_pkg::OPC_BIT_TEST_SKIP_ZERO);
  endproperty
  a_skip_cause: assert property (p_skip_cause) else $error("skip");
  property p_skip_idle;
    skip_o && !wr_i |=> !skip_o && $stable(acc_o) && $stable(zero_o);
  endproperty
  a_skip_idle: assert property (p_skip_idle) else $error("idle");
  property p_port_clear;
    bcf_w && instr_i[6:0] == PORT_ADDR |=>
      port_latch_o[$past(instr_i[9:7])] == 1'b0;
  endproperty
  a_port_clear: assert property (p_port_clear) else $error("port");
endmodule : frabo_core_sva
bind frabo_core frabo_core_sva #(.PORT_ADDR(PORT_ADDR)) u_frabo_core_sva (
  .clk_i(clk_i), .resetn_i(resetn_i), .instr_i(instr_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .port_latch_o(port_latch_o),
  .acc_o(acc_o), .carry_o(carry_o), .zero_o(zero_o), .skip_o(skip_o),
  .nibble_overflow_flag_o(nibble_overflow_flag_o));

// ---- frabo_pmem.sv ----
// Program memory stand-in: one instruction word per clock.
// Assumes the bench steps it; an empty slot reads as a no-op word.
`timescale 1ns/10ps
module frabo_pmem (
  // Bench side
  input wire logic [13:0] word_i,
  input wire logic valid_i,
  // Core side
  output logic [13:0] instr_o
);
  // All-zero decodes to no supported opcode, so it does nothing
  assign instr_o = valid_i ? word_i : 14'h0000;
endmodule : frabo_pmem

// ---- tb_top.sv ----
// Self-checking bench for the file-register ALU block.
// Assumes the checker is bound in and program memory feeds instr_i.
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {
    logic [7:0] acc, fa, fv, st;
    logic [13:0] op, op2;
    logic [7:0] eacc, efv, est;
  } frabo_row_type;
  logic clk_i, resetn_i, wr_i, rd_i, valid, carry_o, nf_o, zero_o, skip_o;
  logic [7:0] addr_i, wdata_i, rdata_o, port_pins_i, port_latch_o, acc_o, v;
  logic [13:0] word, instr;
  int miscompares, checks_done;
  frabo_row_type r;
  // Rows: acc, file addr, file, status, word, next word, expectations
  frabo_row_type rows [7] = '{
    '{8'h17, 8'h10, 8'hC2, 8'h00, 14'h0710, 14'h0000, 8'hD9, 8'hC2, 8'h00},
    '{8'h88, 8'h7F, 8'h78, 8'h00, 14'h07FF, 14'h0000, 8'h88, 8'h00, 8'h07},
    '{8'h17, 8'h10, 8'hC2, 8'h03, 14'h0590, 14'h0000, 8'h17, 8'h02, 8'h03},
    '{8'h0F, 8'h00, 8'hF0, 8'h00, 14'h0500, 14'h0000, 8'h00, 8'hF0, 8'h04},
    '{8'h33, 8'h10, 8'hC7, 8'h05, 14'h1390, 14'h0000, 8'h33, 8'h47, 8'h05},
    '{8'h20, 8'h10, 8'h4D, 8'h02, 14'h1890, 14'h0710, 8'h20, 8'h4D, 8'h02},
    '{8'h20, 8'h10, 8'h4F, 8'h02, 14'h1890, 14'h0710, 8'h6F, 8'h4F, 8'h00}};
  frabo_core u_frabo_core (.clk_i(clk_i), .resetn_i(resetn_i),
    .instr_i(instr), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .port_pins_i(port_pins_i),
    .port_latch_o(port_latch_o), .acc_o(acc_o), .carry_o(carry_o),
    .nibble_overflow_flag_o(nf_o), .zero_o(zero_o), .skip_o(skip_o));
  frabo_pmem u_frabo_pmem (.word_i(word), .valid_i(valid), .instr_o(instr));
  always #5 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // One bus cycle; read data are taken in the cycle after the strobe
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : xfer
  // Two words back to back, so a skip has a real word to discard
  task automatic run2(input logic [13:0] a, b);
    @(posedge clk_i);
    word <= a;
    valid <= 1'b1;
    @(posedge clk_i);
    word <= b;
    #1;
    chk({7'h00, skip_o}, {7'h00, a == 14'h1890 && !r.fv[1]});
    @(posedge clk_i);
    valid <= 1'b0;
  endtask : run2
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #50000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {clk_i, resetn_i, wr_i, rd_i, valid, addr_i, wdata_i, word} = '0;
    port_pins_i = 8'h5A;
    repeat (10) @(posedge clk_i);
    chk(acc_o, 8'h00);
    resetn_i <= 1'b1;
    xfer(1'b1, frabo_pkg::ADDR_CTRL, 8'h01);
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      xfer(1'b1, r.fa, r.fv);
      xfer(1'b1, frabo_pkg::ADDR_ACC, r.acc);
      xfer(1'b1, frabo_pkg::ADDR_STATUS, r.st);
      run2(r.op, r.op2);
      xfer(1'b0, frabo_pkg::ADDR_ACC, 8'h00);
      chk(v, r.eacc);
      xfer(1'b0, r.fa, 8'h00);
      chk(v, r.efv);
      xfer(1'b0, frabo_pkg::ADDR_STATUS, 8'h00);
      chk(v & 8'h07, r.est);
      $display("row %0d done", i);
    end
    // Unmapped read, clear of a port bit, halted core, second reset
    xfer(1'b0, 8'h90, 8'h00);
    chk(v, 8'h00);
    xfer(1'b0, 8'h06, 8'h00);
    chk(v, 8'h5A);
    @(posedge clk_i);
    #1;
    chk(rdata_o, 8'h00);
    run2(14'h1086, 14'h0000);
    chk(port_latch_o, 8'h58);
    xfer(1'b1, frabo_pkg::ADDR_CTRL, 8'h00);
    run2(14'h0710, 14'h0000);
    chk(acc_o, 8'h6F);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    chk({carry_o, nf_o, zero_o, skip_o, 4'h0} | port_latch_o | acc_o, 8'h00);
    $display("special cases done");
    tally_and_finish();
  end
endmodule : tb_top
